// file: core/agc_pkg.sv
// Constants, types and helpers for the general and output format registers
// Notes on behaviour
// - Writing 1 to the RMS enable bit restarts the RMS computation from cleared results; 0 disables it.
// - With the checksum enable set, every byte read out is followed by a CRC and every byte written must be followed by a matching CRC.
// - Writing 1 to the statistics enable clears min, max and latest code, which then track each conversion; with 0 they hold.
// - With the window compare enable at 0 the comparator is held in reset; at 1 it runs.
// - The conversion start trigger bit is write-only and always reads back as 0.
// - Without the trigger, a manual-mode data high read starts a conversion at the ninth SCL fall of the address byte; SCL is stretched until it ends.
// - Writing 1 to the trigger bit starts a conversion with no SCL stretching.
// - The force-analog bit makes every channel an analog input regardless of other configuration.
// - Writing 1 to the offset trim bit starts a calibration, and the bit drops to 0 by itself when it is done.
// - Writing 1 to the soft reset bit restores all registers but the data registers to defaults, then the bit reads 0 and the brownout flag is 1.
// - With the debug pattern bit set, conversion data reads return the constant code 0xA5A.
// - The tag select field appends nothing, a 4-bit channel id, or 4 status flags after the data; 11 is reserved.
// - Bit 6 and bits 3 to 0 of the output format register always read as zero.
// - The brownout flag is set by power-up and by soft reset, and writing 1 to it clears it.
// - While an inbound checksum error is flagged, only writes to addresses 0x00 and 0x01 take effect.
// - In manual trigger mode conversions start only on host action; in autonomous mode an internal timer starts them.
package agc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_GENERAL = 8'h01;
  localparam logic [7:0] REG_FORMAT  = 8'h02;
  localparam logic [7:0] REG_DATA_HI = 8'h10;
  localparam logic [7:0] REG_DATA_LO = 8'h11;

  localparam int GEN_RMS   = 7;
  localparam int GEN_CRC   = 6;
  localparam int GEN_STATS = 5;
  localparam int GEN_WIN   = 4;
  localparam int GEN_TRIG  = 3;
  localparam int GEN_FORCE = 2;
  localparam int GEN_CAL   = 1;
  localparam int GEN_SRST  = 0;
  localparam logic [7:0] GEN_STORE_MASK = 8'hf6;
  localparam logic [7:0] GEN_RESET      = 8'h00;

  localparam int FMT_DEBUG   = 7;
  localparam int FMT_TAG_LSB = 4;
  localparam logic [7:0] FMT_MASK  = 8'hb0;
  localparam logic [7:0] FMT_RESET = 8'h00;

  localparam int STAT_CRC_ERR  = 1;
  localparam int STAT_BROWNOUT = 0;
  localparam logic [7:0] STATUS_FIXED = 8'h80;

  localparam logic [1:0]  TAG_CHAN   = 2'h1;
  localparam logic [1:0]  TAG_FLAGS  = 2'h2;
  localparam logic [11:0] DEBUG_CODE = 12'ha5a;
  localparam logic [11:0] MIN_CLEAR  = 12'hfff;

  // Bus address and checksum setup, plain defaults
  localparam logic [6:0] DEV_ADDR = 7'h10;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 8;
  localparam int OSC_PERIOD_NS  = 160;
  localparam int CONV_TIME_NS   = 1600;
  localparam int CAL_TIME_NS    = 3200;
  localparam int AUTO_PERIOD_NS = 8000;
  localparam logic [7:0] CONV_CYCLES =
    8'((CONV_TIME_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS);
  localparam logic [7:0] CAL_CYCLES =
    8'((CAL_TIME_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS);
  localparam logic [9:0] AUTO_CYCLES =
    10'(AUTO_PERIOD_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WR, ST_RD, ST_SKIP
  } agc_link_state_t;

  function automatic logic [7:0] agc_crc8(input logic [7:0] d);
    logic [7:0] c;
    c = CRC_INIT ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

endpackage

// file: core/agc_reg_bank.sv
// Register bank with I2C slave, conversion control and data formatting
`timescale 1ns/1ps
`default_nettype none
module agc_reg_bank #(
  parameter logic [6:0] DEVICE_ADDRESS = agc_pkg::DEV_ADDR
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        osc_clk_in,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic [11:0] adc_code_in,
  input  wire logic [3:0]  channel_select_in,
  input  wire logic        conversion_trigger_mode_in,
  output logic             root_mean_square_enable_out,
  output logic             rms_restart_out,
  output logic             crc_enable_out,
  output logic             window_compare_enable_out,
  output logic             window_compare_reset_out,
  output logic             force_analog_channels_out,
  output logic [11:0]      stats_min_out,
  output logic [11:0]      stats_max_out,
  output logic [11:0]      stats_latest_out
);
  import agc_pkg::*;

  if (DEVICE_ADDRESS[6:3] == 4'h0) begin : g_chk
    $error("Device address lies in the reserved range");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic scl_s1_reg, scl_s2_reg, scl_q_reg;
  logic sda_s1_reg, sda_s2_reg, sda_q_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {scl_s1_reg, scl_s2_reg, scl_q_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_q_reg} <= 3'h7;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_q_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_q_reg  <= sda_s2_reg;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s2_reg && !scl_q_reg;
  assign scl_fall  = !scl_s2_reg && scl_q_reg;
  assign bus_start = scl_s2_reg && scl_q_reg && sda_q_reg && !sda_s2_reg;
  assign bus_stop  = scl_s2_reg && scl_q_reg && !sda_q_reg && sda_s2_reg;

  // ****************************************************************
  // Shared state
  // ****************************************************************
  agc_link_state_t state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg, tx_reg, held_reg, ptr_reg;
  logic        sda_oe_reg, crc_phase_reg, nack_reg, load_reg;
  logic        stretch_reg, host_start_reg, crc_set_reg;
  logic        wr_stb_reg;
  logic [7:0]  wr_addr_reg, wr_data_reg;
  logic [7:0]  general_reg, format_reg, rd_data;
  logic        crc_err_reg, brownout_reg, srst_reg, rms_restart_reg;
  logic        busy_reg, kind_cal_reg, req_tgl_reg;
  logic [11:0] result_reg, osc_result_reg;
  logic [9:0]  auto_cnt_reg;
  logic        done_s1_reg, done_s2_reg, done_q_reg, done_pulse, done_tgl_reg;

  logic       crc_on, wr_ok, gen_wr, stat_wr, fmt_wr, stats_clear;
  logic       trig_start, auto_start, conv_start, cal_start;
  logic [7:0] rx_byte, held_crc, tx_next;
  assign crc_on   = general_reg[GEN_CRC];
  assign held_crc = agc_crc8(held_reg);
  assign rx_byte  = crc_on ? held_reg : shift_reg;
  assign tx_next  = crc_phase_reg ? held_crc : rd_data;
  assign wr_ok    = wr_stb_reg &&
                    (!crc_err_reg || wr_addr_reg <= REG_GENERAL);
  assign gen_wr   = wr_ok && wr_addr_reg == REG_GENERAL;
  assign stat_wr  = wr_ok && wr_addr_reg == REG_STATUS;
  assign fmt_wr   = wr_ok && wr_addr_reg == REG_FORMAT;
  assign stats_clear = gen_wr && wr_data_reg[GEN_STATS];
  assign trig_start  = gen_wr && wr_data_reg[GEN_TRIG];
  assign auto_start  = conversion_trigger_mode_in &&
                       auto_cnt_reg == 10'h000;
  assign conv_start  = (host_start_reg || trig_start || auto_start) &&
                       !busy_reg;
  assign cal_start   = general_reg[GEN_CAL] && !busy_reg && !conv_start;

  // ****************************************************************
  // I2C slave
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 4'hf;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      held_reg       <= 8'h00;
      ptr_reg        <= 8'h00;
      sda_oe_reg     <= 1'b0;
      crc_phase_reg  <= 1'b0;
      nack_reg       <= 1'b0;
      load_reg       <= 1'b0;
      stretch_reg    <= 1'b0;
      host_start_reg <= 1'b0;
      crc_set_reg    <= 1'b0;
      wr_stb_reg     <= 1'b0;
      wr_addr_reg    <= 8'h00;
      wr_data_reg    <= 8'h00;
    end else begin
      host_start_reg <= 1'b0;
      crc_set_reg    <= 1'b0;
      wr_stb_reg     <= 1'b0;
      load_reg       <= done_pulse && stretch_reg;
      if (load_reg) begin
        // First bit goes out in the same cycle SCL is let go
        stretch_reg <= 1'b0;
        tx_reg      <= tx_next;
        sda_oe_reg  <= !tx_next[7];
        if (!crc_phase_reg) begin
          held_reg <= rd_data;
        end
      end
      if (bus_start) begin
        state_reg     <= ST_ADDR;
        bit_cnt_reg   <= 4'hf;
        sda_oe_reg    <= 1'b0;
        crc_phase_reg <= 1'b0;
      end else if (bus_stop) begin
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (scl_rise && state_reg != ST_IDLE) begin
        if (bit_cnt_reg < 4'h8) begin
          shift_reg <= {shift_reg[6:0], sda_s2_reg};
        end else if (bit_cnt_reg == 4'h8) begin
          nack_reg <= sda_s2_reg;
        end
      end else if (scl_fall && state_reg != ST_IDLE) begin
        if (bit_cnt_reg == 4'hf) begin
          bit_cnt_reg <= 4'h0;
        end else if (bit_cnt_reg < 4'h7) begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (state_reg == ST_RD) begin
            tx_reg     <= {tx_reg[6:0], 1'b0};
            sda_oe_reg <= !tx_reg[6];
          end
        end else if (bit_cnt_reg == 4'h7) begin
          bit_cnt_reg <= 4'h8;
          sda_oe_reg  <= (state_reg == ST_ADDR &&
                          shift_reg[7:1] == DEVICE_ADDRESS) ||
                         state_reg == ST_REG || state_reg == ST_WR;
        end else begin
          bit_cnt_reg <= 4'h0;
          sda_oe_reg  <= 1'b0;
          case (state_reg)
            ST_ADDR: begin
              if (shift_reg[7:1] != DEVICE_ADDRESS) begin
                state_reg <= ST_SKIP;
              end else if (!shift_reg[0]) begin
                state_reg <= ST_REG;
              end else begin
                state_reg <= ST_RD;
                if (ptr_reg == REG_DATA_HI &&
                    !conversion_trigger_mode_in) begin
                  host_start_reg <= 1'b1;
                  stretch_reg    <= 1'b1;
                end else begin
                  load_reg <= 1'b1;
                end
              end
            end
            ST_REG, ST_WR: begin
              if (crc_on && !crc_phase_reg) begin
                held_reg      <= shift_reg;
                crc_phase_reg <= 1'b1;
              end else begin
                crc_phase_reg <= 1'b0;
                if (crc_on && held_crc != shift_reg) begin
                  crc_set_reg <= 1'b1;
                end else if (state_reg == ST_REG) begin
                  ptr_reg   <= rx_byte;
                  state_reg <= ST_WR;
                end else begin
                  wr_stb_reg  <= 1'b1;
                  wr_addr_reg <= ptr_reg;
                  wr_data_reg <= rx_byte;
                  ptr_reg     <= ptr_reg + 8'h01;
                end
              end
            end
            ST_RD: begin
              if (nack_reg) begin
                state_reg <= ST_SKIP;
              end else begin
                load_reg <= 1'b1;
                if (crc_on && !crc_phase_reg) begin
                  crc_phase_reg <= 1'b1;
                end else begin
                  crc_phase_reg <= 1'b0;
                  ptr_reg       <= ptr_reg + 8'h01;
                end
              end
            end
            default: begin
              state_reg <= ST_SKIP;
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      general_reg  <= GEN_RESET;
      format_reg   <= FMT_RESET;
      crc_err_reg  <= 1'b0;
      brownout_reg <= 1'b1;
    end else if (srst_reg) begin
      general_reg  <= GEN_RESET;
      format_reg   <= FMT_RESET;
      crc_err_reg  <= 1'b0;
      brownout_reg <= 1'b1;
    end else begin
      if (done_pulse && kind_cal_reg) begin
        general_reg[GEN_CAL] <= 1'b0;
      end
      if (gen_wr) begin
        general_reg <= wr_data_reg & GEN_STORE_MASK;
      end
      if (fmt_wr) begin
        format_reg <= wr_data_reg & FMT_MASK;
      end
      // Set beats a same-cycle clear
      if (crc_set_reg) begin
        crc_err_reg <= 1'b1;
      end else if (stat_wr && wr_data_reg[STAT_CRC_ERR]) begin
        crc_err_reg <= 1'b0;
      end
      if (stat_wr && wr_data_reg[STAT_BROWNOUT]) begin
        brownout_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      srst_reg        <= 1'b0;
      rms_restart_reg <= 1'b0;
    end else begin
      srst_reg        <= gen_wr && wr_data_reg[GEN_SRST];
      rms_restart_reg <= gen_wr && wr_data_reg[GEN_RMS];
    end
  end

  logic [11:0] code;
  logic [3:0]  tag;
  always_comb begin
    code = format_reg[FMT_DEBUG] ? DEBUG_CODE : result_reg;
    case (format_reg[FMT_TAG_LSB +: 2])
      TAG_CHAN:  tag = channel_select_in;
      TAG_FLAGS: tag = {busy_reg, crc_err_reg, brownout_reg,
                        general_reg[GEN_CAL]};
      default:   tag = 4'h0;
    endcase
    case (ptr_reg)
      REG_STATUS:  rd_data = STATUS_FIXED |
                             {6'h00, crc_err_reg, brownout_reg};
      REG_GENERAL: rd_data = general_reg & GEN_STORE_MASK;
      REG_FORMAT:  rd_data = format_reg & FMT_MASK;
      REG_DATA_HI: rd_data = code[11:4];
      REG_DATA_LO: rd_data = {code[3:0], tag};
      default:     rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Conversion control
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_cnt_reg <= AUTO_CYCLES - 10'h001;
    end else if (!conversion_trigger_mode_in || auto_cnt_reg == 10'h000) begin
      auto_cnt_reg <= AUTO_CYCLES - 10'h001;
    end else begin
      auto_cnt_reg <= auto_cnt_reg - 10'h001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_reg     <= 1'b0;
      kind_cal_reg <= 1'b0;
      req_tgl_reg  <= 1'b0;
    end else if (conv_start) begin
      busy_reg     <= 1'b1;
      kind_cal_reg <= 1'b0;
      req_tgl_reg  <= !req_tgl_reg;
    end else if (cal_start) begin
      busy_reg     <= 1'b1;
      kind_cal_reg <= 1'b1;
      req_tgl_reg  <= !req_tgl_reg;
    end else if (done_pulse) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {done_s1_reg, done_s2_reg, done_q_reg} <= 3'h0;
      result_reg <= 12'h000;
    end else begin
      done_s1_reg <= done_tgl_reg;
      done_s2_reg <= done_s1_reg;
      done_q_reg  <= done_s2_reg;
      // Oscillator result holds until the next conversion ends
      if (done_pulse && !kind_cal_reg) begin
        result_reg <= osc_result_reg;
      end
    end
  end
  assign done_pulse = done_s2_reg ^ done_q_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stats_min_out    <= MIN_CLEAR;
      stats_max_out    <= 12'h000;
      stats_latest_out <= 12'h000;
    end else if (stats_clear || srst_reg) begin
      stats_min_out    <= MIN_CLEAR;
      stats_max_out    <= 12'h000;
      stats_latest_out <= 12'h000;
    end else if (done_pulse && !kind_cal_reg &&
                 general_reg[GEN_STATS]) begin
      stats_latest_out <= osc_result_reg;
      if (osc_result_reg < stats_min_out) begin
        stats_min_out <= osc_result_reg;
      end
      if (osc_result_reg > stats_max_out) begin
        stats_max_out <= osc_result_reg;
      end
    end
  end

  // ****************************************************************
  // Oscillator domain
  // ****************************************************************
  logic       req_s1_reg, req_s2_reg, req_q_reg, osc_run_reg;
  logic [7:0] osc_cnt_reg;
  always_ff @(posedge osc_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {req_s1_reg, req_s2_reg, req_q_reg} <= 3'h0;
      osc_run_reg    <= 1'b0;
      osc_cnt_reg    <= 8'h00;
      done_tgl_reg   <= 1'b0;
      osc_result_reg <= 12'h000;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_q_reg  <= req_s2_reg;
      // Kind is steady while the request toggle crosses
      if (req_s2_reg ^ req_q_reg) begin
        osc_run_reg <= 1'b1;
        osc_cnt_reg <= (kind_cal_reg ? CAL_CYCLES : CONV_CYCLES) - 8'h01;
      end else if (osc_run_reg) begin
        if (osc_cnt_reg == 8'h00) begin
          osc_run_reg  <= 1'b0;
          done_tgl_reg <= !done_tgl_reg;
          if (!kind_cal_reg) begin
            osc_result_reg <= adc_code_in;
          end
        end else begin
          osc_cnt_reg <= osc_cnt_reg - 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe_out = stretch_reg;
  assign sda_oe_out = sda_oe_reg;
  assign root_mean_square_enable_out = general_reg[GEN_RMS];
  assign rms_restart_out           = rms_restart_reg;
  assign crc_enable_out            = crc_on;
  assign window_compare_enable_out = general_reg[GEN_WIN];
  assign window_compare_reset_out  = !general_reg[GEN_WIN];
  assign force_analog_channels_out = general_reg[GEN_FORCE];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_trig_reads_zero;
    @(posedge clk_in) disable iff (rst_in)
    ptr_reg == REG_GENERAL |-> !rd_data[GEN_TRIG] && !rd_data[GEN_SRST];
  endproperty
  a_trig_reads_zero: assert property (p_trig_reads_zero)
    else $error("Write-only bits read back set");

  property p_fmt_reserved;
    @(posedge clk_in) disable iff (rst_in)
    ptr_reg == REG_FORMAT |-> rd_data[6] == 1'b0 && rd_data[3:0] == 4'h0;
  endproperty
  a_fmt_reserved: assert property (p_fmt_reserved)
    else $error("Reserved format bits read nonzero");

  property p_debug_code;
    @(posedge clk_in) disable iff (rst_in)
    format_reg[FMT_DEBUG] && ptr_reg == REG_DATA_HI |-> rd_data == 8'ha5;
  endproperty
  a_debug_code: assert property (p_debug_code)
    else $error("Debug pattern not returned");

  property p_chan_tag;
    @(posedge clk_in) disable iff (rst_in)
    format_reg[5:4] == TAG_CHAN && ptr_reg == REG_DATA_LO
      |-> rd_data[3:0] == channel_select_in;
  endproperty
  a_chan_tag: assert property (p_chan_tag)
    else $error("Channel id tag wrong");

  property p_soft_reset;
    @(posedge clk_in) disable iff (rst_in)
    gen_wr && wr_data_reg[GEN_SRST] |=> ##1 brownout_reg &&
      general_reg == GEN_RESET && format_reg == FMT_RESET;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("Soft reset did not restore defaults");

  property p_write_block;
    @(posedge clk_in) disable iff (rst_in)
    wr_stb_reg && crc_err_reg && wr_addr_reg == REG_FORMAT
      |=> $stable(format_reg);
  endproperty
  a_write_block: assert property (p_write_block)
    else $error("Write passed during checksum error");

  property p_cal_clear;
    @(posedge clk_in) disable iff (rst_in)
    done_pulse && kind_cal_reg && !srst_reg && !gen_wr
      |=> !general_reg[GEN_CAL];
  endproperty
  a_cal_clear: assert property (p_cal_clear)
    else $error("Calibration bit not cleared");

  property p_trig_no_stretch;
    @(posedge clk_in) disable iff (rst_in)
    trig_start && !busy_reg && !stretch_reg |=> busy_reg && !scl_oe_out;
  endproperty
  a_trig_no_stretch: assert property (p_trig_no_stretch)
    else $error("Trigger start stretched SCL");

  sequence s_stretch_hold;
    scl_oe_out throughout busy_reg [*2];
  endsequence
  sequence s_release;
    ##[1:400] !scl_oe_out;
  endsequence
  property p_stretch;
    @(posedge clk_in) disable iff (rst_in)
    $rose(stretch_reg) && !busy_reg |=> s_stretch_hold ##0 s_release;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("SCL stretch not held or not released");

  property p_manual;
    @(posedge clk_in) disable iff (rst_in)
    !conversion_trigger_mode_in && !host_start_reg && !trig_start
      && !cal_start && !busy_reg |=> !busy_reg;
  endproperty
  a_manual: assert property (p_manual)
    else $error("Conversion started without host action");

endmodule
`default_nettype wire

// file: verification/agc_i2c_host.sv
// I2C host model driving the register link
`timescale 1ns/1ps
`default_nettype none
module agc_i2c_host (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_low_out,
  output logic      sda_low_out
);
  initial {scl_low_out, sda_low_out} = 2'h0;
  // Released lines float high through the pull-ups
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    #200 scl_low_out = 1'b0;
    wait (scl_in);
    #200 r = sda_in;
    scl_low_out = 1'b1;
    #200;
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) bit_io(d[i], r[i]);
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    #200 scl_low_out = 1'b0;
    #200 sda_low_out = 1'b1;
    #200 scl_low_out = 1'b1;
    // Keeps the first data bit off the SCL fall
    #200;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #200 scl_low_out = 1'b0;
    #200 sda_low_out = 1'b0;
    #200;
  endtask
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    logic [8:0] r;
    start();
    xfer({agc_pkg::DEV_ADDR, 2'h1}, r);
    xfer({a, 1'b1}, r);
    if (wr) xfer({d, 1'b1}, r);
    else begin
      start();
      xfer({agc_pkg::DEV_ADDR, 2'h3}, r);
      xfer(9'h1ff, r);
    end
    q = r[8:1];
    stop();
  endtask
  // Raw four-byte write, checksum bytes given by the caller
  task automatic wr4(input logic [31:0] w);
    logic [8:0] r;
    start();
    xfer({agc_pkg::DEV_ADDR, 2'h1}, r);
    for (int i = 3; i >= 0; i--) xfer({w[8*i +: 8], 1'b1}, r);
    stop();
  endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the general and output format registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  error_cnt++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import agc_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, osc = 1'b0, mode = 1'b0;
  logic        h_scl, h_sda, scl_oe, sda_oe, rms, crc, win, win_rst, fa, rr;
  logic [11:0] adc = 12'h3c5, s_min, s_max, s_last;
  logic [3:0]  chan = 4'h6;
  logic [7:0]  q, e;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, rr_cnt = 0;
  wire logic   scl = ~(h_scl | scl_oe);
  wire logic   sda = ~(h_sda | sda_oe);
  // Rows: address, written value, expected readback
  logic [23:0] rows [5] = '{24'h02ffb0, 24'h020000, 24'h01b8b0,
                            24'h055500, 24'h01b4b4};
  agc_i2c_host i_host (.scl_in(scl), .sda_in(sda),
    .scl_low_out(h_scl), .sda_low_out(h_sda));
  agc_reg_bank i_dut (.clk_in(clk_in), .rst_in(rst_in), .osc_clk_in(osc),
    .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda),
    .sda_out(), .sda_oe_out(sda_oe), .adc_code_in(adc),
    .channel_select_in(chan), .conversion_trigger_mode_in(mode),
    .root_mean_square_enable_out(rms), .rms_restart_out(rr),
    .crc_enable_out(crc), .window_compare_enable_out(win),
    .window_compare_reset_out(win_rst), .force_analog_channels_out(fa),
    .stats_min_out(s_min), .stats_max_out(s_max),
    .stats_latest_out(s_last));
  initial forever #4 clk_in = ~clk_in;
  initial begin
    #37;
    forever #80 osc = ~osc;
  end
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Restart is a one-cycle pulse, so count every one seen
  always @(posedge clk_in) if (rr) rr_cnt++;
  // Ceiling well above the roughly 86000 cycles the frames need
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    i_host.acc(1'b0, REG_STATUS, 8'h00, q);
    `CHK(q, 8'h81)
    i_host.acc(1'b1, REG_STATUS, 8'h01, q);
    i_host.acc(1'b0, REG_STATUS, 8'h00, q);
    `CHK(q, 8'h80)
    $display("reset test done");
    foreach (rows[i]) begin
      e = rows[i][7:0];
      i_host.acc(1'b1, rows[i][23:16], rows[i][15:8], q);
      i_host.acc(1'b0, rows[i][23:16], 8'h00, q);
      `CHK(q, e)
      if (rows[i][23:16] == REG_GENERAL)
        `CHK({rms, crc, win, win_rst, fa}, {e[7:6], e[4], ~e[4], e[2]})
    end
    `CHK(rr_cnt, 2)
    $display("row test done");
    i_host.acc(1'b0, REG_DATA_HI, 8'h00, q);
    `CHK(q, 8'h3c)
    `CHK({s_min, s_max, s_last}, {3{12'h3c5}})
    i_host.acc(1'b0, REG_DATA_LO, 8'h00, q);
    `CHK(q, 8'h50)
    i_host.acc(1'b1, REG_FORMAT, 8'h90, q);
    i_host.acc(1'b0, REG_DATA_HI, 8'h00, q);
    `CHK(q, DEBUG_CODE[11:4])
    i_host.acc(1'b0, REG_DATA_LO, 8'h00, q);
    `CHK(q, {DEBUG_CODE[3:0], chan})
    $display("data test done");
    adc  <= 12'h1e7;
    mode <= 1'b1;
    repeat (1500) @(posedge clk_in);
    `CHK({s_min, s_max, s_last}, {12'h1e7, 12'h3c5, 12'h1e7})
    mode <= 1'b0;
    $display("autonomous test done");
    i_host.acc(1'b1, REG_FORMAT, 8'h20, q);
    i_host.acc(1'b1, REG_GENERAL, 8'h40, q);
    `CHK(crc, 1'b1)
    i_host.wr4({REG_FORMAT, 8'h0e, 8'hb0, 8'h00});
    i_host.wr4({REG_GENERAL, 8'h07, 8'h00, 8'h00});
    `CHK(crc, 1'b0)
    i_host.acc(1'b0, REG_STATUS, 8'h00, q);
    `CHK(q, 8'h82)
    i_host.acc(1'b0, REG_DATA_LO, 8'h00, q);
    `CHK(q, 8'h74)
    i_host.acc(1'b1, REG_FORMAT, 8'h90, q);
    i_host.acc(1'b0, REG_FORMAT, 8'h00, q);
    `CHK(q, 8'h20)
    $display("checksum test done");
    i_host.acc(1'b1, REG_GENERAL, 8'h02, q);
    i_host.acc(1'b0, REG_GENERAL, 8'h00, q);
    `CHK(q, 8'h00)
    i_host.acc(1'b1, REG_GENERAL, 8'h01, q);
    i_host.acc(1'b0, REG_FORMAT, 8'h00, q);
    `CHK(q, 8'h00)
    i_host.acc(1'b0, REG_STATUS, 8'h00, q);
    `CHK(q, 8'h81)
    `CHK({s_min, s_last}, {MIN_CLEAR, 12'h000})
    $display("soft reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
